// ### verilog/lnp_pkg.sv
`default_nettype none
package lnp_pkg;
   // nibble geometry
   localparam int NIB_W = 4;
   localparam int NIB_MSB = 3;
   // one line bit lasts four system cycles, so the double-rate clock fits two cycles in each bit
   localparam logic [1:0] BIT_PHASE_LAST = 2'h3;
   localparam logic [1:0] BIT_PHASE_START = 2'h0;
   localparam logic [1:0] BIT_CNT_LAST = 2'h3;
   localparam logic [1:0] BIT_CNT_MID = 2'h1;
   localparam logic [1:0] BIT_CNT_START = 2'h0;
   // receive serial clock falls when the phase leaves this value
   localparam logic [1:0] RX_FALL_PHASE = 2'h1;
   // transmit elastic store
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_AW = 2;
   localparam logic [FIFO_AW:0] FIFO_WR_CENTRE = 3'h2;
   localparam logic [FIFO_AW:0] FIFO_RD_CENTRE = 3'h0;
   localparam logic [FIFO_AW:0] FIFO_FULL_FILL = 3'h4;
   localparam logic [FIFO_AW:0] PTR_STEP = 3'h1;
   localparam logic [1:0] CNT_STEP = 2'h1;
   localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

   // transmit timing modes
   typedef enum logic [1:0] {
      lnp_master_parallel,
      lnp_slave_parallel,
      lnp_loop_parallel,
      lnp_serial
   } lnp_tx_mode_type;

   // transmit line side pins, two-way style with enables
   typedef struct packed {
      logic coded_line_out_pos;
      logic coded_line_out_neg;
      logic coded_line_oe;
      logic monitor_line_out_pos;
      logic monitor_line_out_neg;
      logic monitor_line_oe;
      logic optical_data_out_pos;
      logic optical_data_out_neg;
   } lnp_line_out_type;
endpackage : lnp_pkg
`default_nettype wire

// ### verilog/lnp_tx_serializer.sv
`timescale 1ns/10ps
`default_nettype none
module lnp_tx_serializer (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic shift_i,
   input wire logic [lnp_pkg::NIB_W-1:0] nibble_i,
   output logic bit_o
);
   logic [lnp_pkg::NIB_W-1:0] shreg;

   // load wins over shift because the load lands on the last bit's slot end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shreg <= lnp_pkg::NIB_ZERO;
      end else if (load_i) begin
         shreg <= nibble_i;
      end else if (shift_i) begin
         shreg <= {shreg[lnp_pkg::NIB_MSB-1:0], 1'b0}; // see RQ2
      end
   end

   assign bit_o = shreg[lnp_pkg::NIB_MSB]; // msb goes out first, see RQ2
endmodule : lnp_tx_serializer
`default_nettype wire

// ### verilog/lnp_rx_deserializer.sv
`timescale 1ns/10ps
`default_nettype none
module lnp_rx_deserializer (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic sample_i,
   input wire logic bit_i,
   input wire logic last_bit_i,
   input wire logic update_i,
   input wire logic los_i,
   output logic [lnp_pkg::NIB_W-1:0] nibble_o
);
   logic [lnp_pkg::NIB_W-1:0] shreg;
   logic [lnp_pkg::NIB_W-1:0] held;
   wire [lnp_pkg::NIB_W-1:0] next_shreg = {shreg[lnp_pkg::NIB_MSB-1:0], bit_i};

   // first bit shifts up to bit 3 after four samples
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shreg <= lnp_pkg::NIB_ZERO;
         held <= lnp_pkg::NIB_ZERO;
      end else if (sample_i) begin
         shreg <= next_shreg; // see RQ10
         if (last_bit_i) begin
            held <= next_shreg; // see RQ21
         end
      end
   end

   // output moves only on the nibble clock's falling edge; loss of signal forces low
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nibble_o <= lnp_pkg::NIB_ZERO;
      end else if (los_i) begin
         nibble_o <= lnp_pkg::NIB_ZERO; // see RQ11
      end else if (update_i) begin
         nibble_o <= held; // see RQ13
      end
   end
endmodule : lnp_rx_deserializer
`default_nettype wire

// ### verilog/lnp_line_port.sv
// Operation
// RQ1: parallel mode captures a four-bit nibble on the transmit nibble clock edge.
// RQ2: each transmit nibble goes out msb first, then bits 2, 1, 0.
// RQ3: system supplies the parallel clock, source synchronous with the reference.
// RQ4: nibble clock output only in master parallel mode, running through reset.
// RQ5: serial mode samples serial data on the serial clock's rising edge.
// RQ6: coded line outputs float when transmitter disabled, stay driven in reset.
// RQ7: monitor output carries the coded signal only when redundant select set.
// RQ8: double-rate transmit clock output times coded data, running through reset.
// RQ9: optical outputs carry raw data only in fiber pass-through mode.
// RQ10: receive bits pack into nibbles with the first bit in bit 3.
// RQ11: loss of signal forces all receive nibble outputs low.
// RQ12: receive nibble clock comes from dividing the recovered clock, runs in reset.
// RQ13: receive nibbles change on the falling edge of the nibble clock.
// RQ14: nibble clock keeps running on the frozen phase during loss of signal.
// RQ15: serial receive data launched on falling serial clock edge; clock runs in reset.
// RQ16: serial receive data held at zero during loss of signal.
// RQ17: serial receive clock keeps steady on the frozen phase during loss of signal.
// RQ18: clock inversion set captures transmit data on the falling edge instead.
// RQ19: coax mode uses coded outputs; fiber mode disables coding, uses optical.
// RQ20: fifo reset centres the pointers and clears the fifo error flag.
// RQ21: four line bits per nibble clock period on both directions.
`timescale 1ns/10ps
`default_nettype none
module lnp_line_port (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire lnp_pkg::lnp_tx_mode_type tx_mode_i,
   input wire logic tx_enable_i,
   input wire logic tx_clock_invert_i,
   input wire logic coax_mode_select_i,
   input wire logic redundant_monitor_select_i,
   input wire logic fifo_pointer_reset_i,
   input wire logic [lnp_pkg::NIB_W-1:0] tx_nibble_in_i,
   input wire logic tx_nibble_clock_in_i,
   input wire logic tx_serial_data_in_pos_i,
   input wire logic tx_serial_clock_in_pos_i,
   input wire logic line_input_pos_i,
   input wire logic rx_los_i,
   input wire logic [1:0] rx_dll_phase_i,
   output logic tx_nibble_clock_out_o,
   output logic tx_nibble_clock_oe_o,
   output logic tx_double_rate_clock_out_o,
   output lnp_pkg::lnp_line_out_type line_out_o,
   output logic fifo_error_flag_o,
   output logic [lnp_pkg::NIB_W-1:0] rx_nibble_out_o,
   output logic rx_nibble_clock_out_o,
   output logic rx_serial_data_out_pos_o,
   output logic rx_serial_clock_out_pos_o
);
   // ---------------- transmit timing ----------------
   // the dividers start from their initial value and never see reset, so that
   // every clock derived from them keeps running while the block is held in reset
   logic [1:0] tx_phase = lnp_pkg::BIT_PHASE_START;
   logic [1:0] tx_bit_cnt = lnp_pkg::BIT_CNT_START;
   logic dbl_clk;
   logic nib_clk_q;
   logic ser_clk_q;

   // slot and nibble boundaries, and the mode decode used all over the port
   wire tx_bit_end = (tx_phase == lnp_pkg::BIT_PHASE_LAST);
   wire tx_nib_end = tx_bit_end && (tx_bit_cnt == lnp_pkg::BIT_CNT_LAST);
   wire tx_half = tx_phase[1];
   wire is_master = (tx_mode_i == lnp_pkg::lnp_master_parallel);
   wire is_serial = (tx_mode_i == lnp_pkg::lnp_serial);

   // free-running dividers take no reset, so the derived clocks run through it
   always_ff @(posedge sys_clk_i) begin
      tx_phase <= tx_phase + lnp_pkg::CNT_STEP;
      dbl_clk <= ~tx_phase[0]; // see RQ8

      if (tx_bit_end) begin
         tx_bit_cnt <= tx_bit_cnt + lnp_pkg::CNT_STEP; // see RQ21
      end
   end

   // the double-rate clock is a toggle of the system clock, so it never stops
   assign tx_double_rate_clock_out_o = dbl_clk; // see RQ8

   // master nibble clock: high for the first two bit slots of each nibble; like the
   // dividers it takes no reset, since the framer may need it while the port is reset
   always_ff @(posedge sys_clk_i) begin
      tx_nibble_clock_out_o <= ~tx_bit_cnt[1]; // see RQ4
   end

   // driver enabled only in master mode; reset does not touch the mode input
   assign tx_nibble_clock_oe_o = is_master; // see RQ4

   // ---------------- transmit capture ----------------
   // previous samples of the incoming clocks, for edge detection
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nib_clk_q <= 1'b0;
         ser_clk_q <= 1'b0;
      end else begin
         nib_clk_q <= tx_nibble_clock_in_i;
         ser_clk_q <= tx_serial_clock_in_pos_i;
      end
   end

   // one edge picker serves both clock inputs, so inversion acts alike on each
   function automatic logic tx_nibble_clock_in_edge(input logic prev, input logic cur, input logic inv);
      tx_nibble_clock_in_edge = inv ? (prev & ~cur) : (~prev & cur);
   endfunction : tx_nibble_clock_in_edge

   // inversion swaps the sampling edge for the serial input, and for the parallel input outside master mode
   wire nib_edge = tx_nibble_clock_in_edge(nib_clk_q, tx_nibble_clock_in_i, tx_clock_invert_i); // see RQ18
   wire ser_edge = tx_nibble_clock_in_edge(ser_clk_q, tx_serial_clock_in_pos_i, tx_clock_invert_i); // see RQ5
   // master mode captures at mid-nibble of its own clock, where data has settled
   wire own_edge = tx_bit_end && (tx_bit_cnt == lnp_pkg::BIT_CNT_MID);
   wire par_capture = is_master ? own_edge : nib_edge; // see RQ1
   wire ser_capture = is_serial && ser_edge; // see RQ5

   // serial bits gather into nibbles so both modes share one elastic store
   logic [lnp_pkg::NIB_W-1:0] ser_acc;
   logic [1:0] ser_cnt;
   wire [lnp_pkg::NIB_W-1:0] next_ser_acc = {ser_acc[lnp_pkg::NIB_MSB-1:0],
                                             tx_serial_data_in_pos_i};
   wire ser_full = ser_capture && (ser_cnt == lnp_pkg::BIT_CNT_LAST);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ser_acc <= lnp_pkg::NIB_ZERO;
         ser_cnt <= lnp_pkg::BIT_CNT_START;
      end else if (ser_capture) begin
         ser_acc <= next_ser_acc;
         ser_cnt <= ser_cnt + lnp_pkg::CNT_STEP;
      end
   end


   // one push per nibble, from whichever input the mode selects
   wire push = is_serial ? ser_full : (par_capture && !is_serial);
   wire [lnp_pkg::NIB_W-1:0] push_data = is_serial ? next_ser_acc : tx_nibble_in_i;

   // ---------------- transmit elastic store ----------------
   logic [lnp_pkg::NIB_W-1:0] fifo_mem [lnp_pkg::FIFO_DEPTH];
   logic [lnp_pkg::FIFO_AW:0] wr_ptr;
   logic [lnp_pkg::FIFO_AW:0] rd_ptr;


   // the pointers carry one spare bit, so a full store and an empty one differ
   wire [lnp_pkg::FIFO_AW:0] fill = wr_ptr - rd_ptr;
   wire fifo_empty = (fill == '0);
   wire fifo_full = (fill == lnp_pkg::FIFO_FULL_FILL);
   wire pop = tx_nib_end;
   wire do_push = push && !fifo_full;
   wire do_pop = pop && !fifo_empty;
   wire overflow = push && fifo_full;
   wire underflow = pop && fifo_empty;
   wire [lnp_pkg::NIB_W-1:0] fifo_head = fifo_mem[rd_ptr[lnp_pkg::FIFO_AW-1:0]];

   // the store holds only data, so no reset is needed on the array
   always_ff @(posedge sys_clk_i) begin
      if (do_push) begin
         fifo_mem[wr_ptr[lnp_pkg::FIFO_AW-1:0]] <= push_data; // see RQ1
      end
   end

   // pointers sit centred while the reset control is held
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= lnp_pkg::FIFO_WR_CENTRE;
         rd_ptr <= lnp_pkg::FIFO_RD_CENTRE;
      end else if (fifo_pointer_reset_i) begin
         wr_ptr <= lnp_pkg::FIFO_WR_CENTRE; // see RQ20
         rd_ptr <= lnp_pkg::FIFO_RD_CENTRE; // see RQ20
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + lnp_pkg::PTR_STEP;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + lnp_pkg::PTR_STEP;
         end
      end
   end

   // sticky slip flag; the reset control is its only clear and wins while held
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fifo_error_flag_o <= 1'b0;
      end else if (fifo_pointer_reset_i) begin
         fifo_error_flag_o <= 1'b0; // see RQ20
      end else if (overflow || underflow) begin
         fifo_error_flag_o <= 1'b1;
      end
   end

   // ---------------- transmit line ----------------
   logic tx_bit;
   // an empty store sends zeros rather than repeating stale data
   wire [lnp_pkg::NIB_W-1:0] load_data = fifo_empty ? lnp_pkg::NIB_ZERO : fifo_head;

   lnp_tx_serializer u_ser (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .load_i(tx_nib_end),
      .shift_i(tx_bit_end),
      .nibble_i(load_data),
      .bit_o(tx_bit)
   );

   // mark-inversion level flips after every one that was sent
   logic cmi_level;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmi_level <= 1'b0;
      end else if (tx_bit_end && tx_bit) begin
         cmi_level <= ~cmi_level;
      end
   end

   // a one holds the alternating level, a zero goes low then high
   wire cmi_sym = tx_bit ? cmi_level : tx_half;
   wire coded = coax_mode_select_i & cmi_sym; // see RQ19
   wire optical = ~coax_mode_select_i & tx_bit; // see RQ9
   wire coded_en = tx_enable_i & coax_mode_select_i; // see RQ6

   lnp_pkg::lnp_line_out_type next_line_out;
   always_comb begin
      next_line_out.coded_line_out_pos = coded;
      next_line_out.coded_line_out_neg = ~coded;
      next_line_out.coded_line_oe = coded_en; // see RQ6
      next_line_out.monitor_line_out_pos = coded; // see RQ7
      next_line_out.monitor_line_out_neg = ~coded;
      next_line_out.monitor_line_oe = coded_en & redundant_monitor_select_i; // see RQ7
      next_line_out.optical_data_out_pos = optical;
      next_line_out.optical_data_out_neg = ~optical & ~coax_mode_select_i;
   end

   // registered line pins take no reset: the drivers stay enabled through it,
   // because the enables keep following the inputs; only the content is idle
   always_ff @(posedge sys_clk_i) begin
      line_out_o <= next_line_out; // see RQ6
   end

   // ---------------- receive ----------------
   // like the transmit side, the receive divider starts by value and ignores reset
   logic [1:0] rx_phase = lnp_pkg::BIT_PHASE_START;
   logic [1:0] rx_bit_cnt = lnp_pkg::BIT_CNT_START;
   logic [1:0] dll_sel;
   logic rx_last_bit;


   // the line is sampled once per slot, at the phase the loop has chosen
   wire rx_sample = (rx_phase == dll_sel);
   wire rx_bit_end = (rx_phase == lnp_pkg::BIT_PHASE_LAST);
   wire rx_fall = (rx_phase == lnp_pkg::RX_FALL_PHASE);
   wire rx_nib_fall = rx_bit_end && (rx_bit_cnt == lnp_pkg::BIT_CNT_MID);
   wire rx_nib_last = (rx_bit_cnt == lnp_pkg::BIT_CNT_LAST);

   // recovered-clock divider runs regardless of signal state and of reset,
   // so the receive clocks stay steady in both
   always_ff @(posedge sys_clk_i) begin
      rx_phase <= rx_phase + lnp_pkg::CNT_STEP; // see RQ12

      if (rx_bit_end) begin
         rx_bit_cnt <= rx_bit_cnt + lnp_pkg::CNT_STEP; // see RQ21
      end
   end

   // phase choice freezes during loss of signal, at the last one in use
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dll_sel <= lnp_pkg::BIT_PHASE_START;
      end else if (!rx_los_i) begin
         dll_sel <= rx_dll_phase_i; // see RQ14
      end
   end

   // sampled bit, held until the serial clock's falling edge launches it
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_last_bit <= 1'b0;
      end else if (rx_sample) begin
         rx_last_bit <= line_input_pos_i;
      end
   end

   // the clocks are registered from the next count, so they line up with it
   wire [1:0] next_rx_phase = rx_phase + lnp_pkg::CNT_STEP;
   wire [1:0] next_rx_cnt = rx_bit_end ? rx_bit_cnt + lnp_pkg::CNT_STEP : rx_bit_cnt;
   wire next_rx_phase_hi = next_rx_phase[1]; // see RQ17
   wire next_rx_cnt_hi = next_rx_cnt[1];

   // serial clock high in the first half of each bit, low in the second; no reset,
   // so both receive clocks keep running while the port is held in reset
   always_ff @(posedge sys_clk_i) begin
      rx_serial_clock_out_pos_o <= ~next_rx_phase_hi; // see RQ15
      rx_nibble_clock_out_o <= ~next_rx_cnt_hi; // see RQ12
   end

   // data moves with the clock's fall; loss of signal holds it at zero
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_serial_data_out_pos_o <= 1'b0;
      end else if (rx_los_i) begin
         rx_serial_data_out_pos_o <= 1'b0; // see RQ16
      end else if (rx_fall) begin
         rx_serial_data_out_pos_o <= rx_last_bit; // see RQ15
      end
   end

   lnp_rx_deserializer u_des (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .sample_i(rx_sample),
      .bit_i(line_input_pos_i),
      .last_bit_i(rx_nib_last),
      .update_i(rx_nib_fall),
      .los_i(rx_los_i),
      .nibble_o(rx_nibble_out_o)
   );
endmodule : lnp_line_port
`default_nettype wire

// ### verif/lnp_line_port_sva.sv
`timescale 1ns/10ps
`default_nettype none
module lnp_line_port_sva (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire lnp_pkg::lnp_tx_mode_type tx_mode_i,
   input wire logic tx_enable_i,
   input wire logic coax_mode_select_i,
   input wire logic redundant_monitor_select_i,
   input wire logic fifo_pointer_reset_i,
   input wire logic rx_los_i,
   input wire logic tx_nibble_clock_oe_o,
   input wire logic tx_double_rate_clock_out_o,
   input wire lnp_pkg::lnp_line_out_type line_out_o,
   input wire logic fifo_error_flag_o,
   input wire logic [lnp_pkg::NIB_W-1:0] rx_nibble_out_o,
   input wire logic rx_nibble_clock_out_o,
   input wire logic rx_serial_data_out_pos_o,
   input wire logic rx_serial_clock_out_pos_o
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   // transmit side gating and clocks
   a_nibclk_oe_mode: assert property (tx_nibble_clock_oe_o ==
      (tx_mode_i == lnp_pkg::lnp_master_parallel)) else $error("nibble clock enable vs mode");
   a_dbl_clk_runs: assert property ($changed(tx_double_rate_clock_out_o)
      |=> $changed(tx_double_rate_clock_out_o)) else $error("double rate clock stalled");
   a_coded_tristate: assert property (!tx_enable_i |=> !line_out_o.coded_line_oe)
      else $error("coded line driven while disabled");
   a_monitor_gate: assert property (!redundant_monitor_select_i
      |=> !line_out_o.monitor_line_oe) else $error("monitor driven while deselected");
   a_optical_idle: assert property (coax_mode_select_i |=>
      !line_out_o.optical_data_out_pos && !line_out_o.optical_data_out_neg)
      else $error("optical active in coax mode");
   a_fifo_clear: assert property (fifo_pointer_reset_i |=> !fifo_error_flag_o)
      else $error("fifo error survives pointer reset");

   // receive side: forced lows and clock shapes
   a_los_nib_low: assert property (rx_los_i |=> rx_nibble_out_o == lnp_pkg::NIB_ZERO)
      else $error("nibble not low under loss of signal");
   a_los_ser_low: assert property (rx_los_i |=> !rx_serial_data_out_pos_o)
      else $error("serial data not low under loss of signal");
   a_nib_on_fall: assert property (!rx_los_i && !$past(rx_los_i)
      && $changed(rx_nibble_out_o) |-> $fell(rx_nibble_clock_out_o))
      else $error("nibble changed off the clock fall");
   a_nibclk_shape: assert property ($fell(rx_nibble_clock_out_o) |->
      !rx_nibble_clock_out_o[*8] ##1 rx_nibble_clock_out_o[*8]) else $error("nibble clock shape");
   a_serclk_shape: assert property ($fell(rx_serial_clock_out_pos_o) |->
      !rx_serial_clock_out_pos_o[*2] ##1 rx_serial_clock_out_pos_o[*2] ##1
      !rx_serial_clock_out_pos_o) else $error("serial clock shape");

   c_los_cycle: cover property (rx_los_i ##1 !rx_los_i);
   c_fifo_err: cover property ($rose(fifo_error_flag_o));
   c_serial_tx: cover property (tx_mode_i == lnp_pkg::lnp_serial && line_out_o.optical_data_out_pos);
endmodule : lnp_line_port_sva

bind lnp_line_port lnp_line_port_sva u_sva (.sys_clk_i, .rst_i, .tx_mode_i, .tx_enable_i,
   .coax_mode_select_i, .redundant_monitor_select_i, .fifo_pointer_reset_i, .rx_los_i,
   .tx_nibble_clock_oe_o, .tx_double_rate_clock_out_o, .line_out_o, .fifo_error_flag_o,
   .rx_nibble_out_o, .rx_nibble_clock_out_o, .rx_serial_data_out_pos_o,
   .rx_serial_clock_out_pos_o);
`default_nettype wire

// ### verif/lnp_framer_model.sv
`timescale 1ns/10ps
`default_nettype none
module lnp_framer_model (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic invert_i,
   input wire logic [3:0] word_i,
   output logic nib_clk_o,
   output logic [3:0] nib_o,
   output logic ser_clk_o,
   output logic ser_o
);
   logic [3:0] tick;
   logic [3:0] nxt;
   logic [3:0] word = 4'h0;
   // launch on the edge the port does not capture on, giving half a period of margin
   always @(negedge sys_clk_i or posedge rst_i) begin
      nxt = tick + 4'h2;
      if (rst_i || !run_i) begin
         // clocks stand still between frames; released data keeps changing
         tick = 4'h0;
         nib_clk_o = 1'b0;
         ser_clk_o = 1'b0;
         nib_o = (nib_o === 4'h5) ? 4'ha : 4'h5;
         ser_o = (ser_o !== 1'b1);
      end else begin
         nib_clk_o = (tick < 4'h8);
         ser_clk_o = !tick[1];
         if (tick == {~invert_i, 3'h0}) begin
            nib_o = word_i;
         end
         if (tick[1:0] == {~invert_i, 1'b0}) begin
            if (nxt[3:2] == 2'h0) begin
               word = word_i;
            end
            ser_o = word[2'h3 - nxt[3:2]];
         end
         tick = tick + 4'h1;
      end
   end
endmodule : lnp_framer_model
`default_nettype wire

// ### verif/tb_lnp_line_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_lnp_line_port;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   lnp_pkg::lnp_tx_mode_type mode = lnp_pkg::lnp_slave_parallel;
   logic en = 1'b0, inv = 1'b0, coax = 1'b0, red = 1'b0, fifo_pointer_reset = 1'b0;
   logic lin = 1'b0, los = 1'b0, run = 1'b0;
   logic [1:0] dll = 2'h2;
   logic [3:0] word = 4'h0;
   logic nclk, sclk, sd, nck, nck_oe, dbl, ferr, rnck, rsd, rsck;
   logic [3:0] nib, rnib;
   lnp_pkg::lnp_line_out_type lo;
   int errors = 0, checks = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   lnp_framer_model u_framer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .run_i(run),
      .invert_i(inv), .word_i(word), .nib_clk_o(nclk), .nib_o(nib), .ser_clk_o(sclk),
      .ser_o(sd));

   lnp_line_port DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tx_mode_i(mode), .tx_enable_i(en),
      .tx_clock_invert_i(inv), .coax_mode_select_i(coax), .redundant_monitor_select_i(red),
      .fifo_pointer_reset_i(fifo_pointer_reset), .tx_nibble_in_i(nib), .tx_nibble_clock_in_i(nclk),
      .tx_serial_data_in_pos_i(sd), .tx_serial_clock_in_pos_i(sclk), .line_input_pos_i(lin),
      .rx_los_i(los), .rx_dll_phase_i(dll), .tx_nibble_clock_out_o(nck),
      .tx_nibble_clock_oe_o(nck_oe), .tx_double_rate_clock_out_o(dbl), .line_out_o(lo),
      .fifo_error_flag_o(ferr), .rx_nibble_out_o(rnib), .rx_nibble_clock_out_o(rnck),
      .rx_serial_data_out_pos_o(rsd), .rx_serial_clock_out_pos_o(rsck));

   // helpers: cycle stepping on the falling edge, comparison, closing report
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : step

   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         errors++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   // clocks during and after reset; master nibble clock pin enable
   task automatic t_reset();
      int a = 0;
      int b = 0;
      int c = 0;
      int d = 0;
      logic p, q, r, s;
      mode = lnp_pkg::lnp_master_parallel;
      step(2);
      chk(nck_oe === 1'b1, "nibble clock off in master mode");
      rst_i = 1'b0;
      step(4);
      // second reset in mid-run: every clock output keeps running through it
      rst_i = 1'b1;
      for (int k = 0; k < 64; k++) begin
         if (k == 32) rst_i = 1'b0;
         p = nck;
         q = dbl;
         r = rnck;
         s = rsck;
         step(1);
         a += (nck !== p);
         b += (dbl !== q);
         c += (rnck !== r);
         d += (rsck !== s);
      end
      chk(a == 8, "master nibble clock period");
      chk(b == 64, "double rate clock period");
      chk(c == 8 && d == 32, "receive clocks stopped in reset");
      mode = lnp_pkg::lnp_slave_parallel;
      step(1);
      chk(nck_oe === 1'b0, "nibble clock on outside master mode");
      $display("test reset done");
   endtask : t_reset

   // one lone nibble 1011 among zeros must reach the optical line msb first
   task automatic t_tx(input lnp_pkg::lnp_tx_mode_type m, input logic iv);
      int i;
      logic [5:0] got;
      mode = m;
      inv = iv;
      coax = 1'b0;
      en = 1'b1;
      fifo_pointer_reset = 1'b1;
      step(1);
      fifo_pointer_reset = 1'b0;
      // framer inputs move by non-blocking writes, as the model acts on this edge too
      run <= 1'b1;
      step(96);
      word <= 4'hb;
      step(16);
      word <= 4'h0;
      for (i = 0; i < 200 && lo.optical_data_out_pos !== 1'b1; i++) step(1);
      if (i == 200) begin
         chk(1'b0, "no data on optical output");
         test_done();
      end
      step(2);
      for (i = 0; i < 6; i++) begin
         got[5-i] = lo.optical_data_out_pos;
         chk(lo.optical_data_out_neg === ~got[5-i], "optical legs not complementary");
         step(4);
      end
      chk(got === 6'b101100, "line bit order");
      chk(lo.coded_line_oe === 1'b0, "coded driver on in fiber mode");
      run <= 1'b0;
      $display("test tx mode %0d invert %0d done", m, iv);
   endtask : t_tx

   // coax mode: driver enables follow enable and redundant select
   task automatic t_gates();
      coax = 1'b1;
      for (int k = 0; k < 4; k++) begin
         en = k[0];
         red = k[1];
         step(2);
         chk(lo.coded_line_oe === k[0], "coded enable");
         chk(lo.monitor_line_oe === (k[0] & k[1]), "monitor enable");
         chk(lo.optical_data_out_pos === 1'b0, "optical active in coax mode");
         chk((lo.coded_line_out_pos ^ lo.coded_line_out_neg) === 1'b1, "coded legs");
         chk(lo.monitor_line_out_pos === lo.coded_line_out_pos, "monitor copy");
      end
      $display("test gates done");
   endtask : t_gates

   // starve the fifo, then clear its error with the pointer reset
   task automatic t_fifo();
      int i;
      mode = lnp_pkg::lnp_serial;
      fifo_pointer_reset = 1'b1;
      step(1);
      fifo_pointer_reset = 1'b0;
      chk(ferr === 1'b0, "error set after pointer reset");
      for (i = 0; i < 100 && ferr !== 1'b1; i++) step(1);
      chk(ferr === 1'b1, "starved fifo raised no error");
      fifo_pointer_reset = 1'b1;
      step(2);
      chk(ferr === 1'b0, "error kept under pointer reset");
      fifo_pointer_reset = 1'b0;
      $display("test fifo done");
   endtask : t_fifo

   // receive a lone 1011, then loss of signal with ones on the line
   task automatic t_rx();
      logic [7:0] w = 8'h0;
      logic [5:0] s = 6'h0;
      logic [3:0] pat = 4'hb;
      bit nok = 1'b0, sok = 1'b0, low = 1'b1;
      int e = 0;
      int f = 0;
      logic pn, ps;
      for (int c = 0; c < 160; c++) begin
         lin = (c >= 64 && c < 80) ? pat[3 - (c - 64) / 4] : 1'b0;
         pn = rnck;
         ps = rsck;
         step(1);
         if (rnck && !pn) begin
            w = {w[3:0], rnib};
            nok |= w inside {8'h0b, 8'h16, 8'h2c, 8'h58, 8'hb0};
         end
         if (rsck && !ps) begin
            s = {s[4:0], rsd};
            sok |= (s === 6'b010110);
         end
      end
      chk(nok, "receive nibble bit order");
      chk(sok, "receive serial stream");
      lin = 1'b1;
      los = 1'b1;
      step(2);
      for (int k = 0; k < 32; k++) begin
         pn = rnck;
         ps = rsck;
         step(1);
         e += (rnck !== pn);
         f += (rsck !== ps);
         low &= (rnib === 4'h0 && rsd === 1'b0);
      end
      chk(low, "outputs not low in loss of signal");
      chk(e == 4 && f == 16, "receive clocks unsteady");
      los = 1'b0;
      lin = 1'b0;
      $display("test rx done");
   endtask : t_rx

   initial begin
      t_reset();
      t_tx(lnp_pkg::lnp_slave_parallel, 1'b0);
      t_tx(lnp_pkg::lnp_loop_parallel, 1'b1);
      t_tx(lnp_pkg::lnp_serial, 1'b0);
      t_tx(lnp_pkg::lnp_serial, 1'b1);
      t_gates();
      t_fifo();
      t_rx();
      test_done();
   end
endmodule : tb_lnp_line_port
`default_nettype wire
